//--- sysctl_cond.v
// Branch condition evaluator over the condition code flags
`timescale 1ns/1ps
module sysctl_cond (
  input  wire [3:0] i_cond,
  input  wire [7:0] i_ccr,
  output reg        o_take
);
  wire c = i_ccr[0];
  wire v = i_ccr[1];
  wire z = i_ccr[2];
  wire n = i_ccr[3];

  always @* begin
    case (i_cond)
      4'h0: o_take = 1'b1;
      4'h1: o_take = 1'b0;
      4'h2: o_take = ~(c | z);
      4'h3: o_take = c | z;
      4'h4: o_take = ~c;
      4'h5: o_take = c;
      4'h6: o_take = ~z;
      4'h7: o_take = z;
      4'h8: o_take = ~v;
      4'h9: o_take = v;
      4'hA: o_take = ~n;
      4'hB: o_take = n;
      4'hC: o_take = ~(n ^ v);
      4'hD: o_take = n ^ v;
      4'hE: o_take = ~(z | (n ^ v));
      default: o_take = z | (n ^ v);
    endcase
  end
endmodule

//--- sysctl_decode.v
// Instruction word decoder for control-transfer and system instructions
`timescale 1ns/1ps
module sysctl_decode (
  input  wire [15:0] i_word,
  output reg  [4:0]  o_opc,
  output wire [3:0]  o_op_field,
  output wire [3:0]  o_op2_field,
  output wire [2:0]  o_areg_sel,
  output wire [3:0]  o_dreg_sel,
  output reg  [1:0]  o_ext_size,
  output reg  [3:0]  o_cond,
  output wire [1:0]  o_trap_vec,
  output wire        o_ctl_exr
);
`include "sysctl_map.vh"

  assign o_op_field  = i_word[`OP_HI:`OP_LO];
  assign o_op2_field = i_word[`OP2_HI:`OP2_LO];
  assign o_areg_sel  = i_word[`RSEL_HI:`RSEL_LO];
  assign o_dreg_sel  = i_word[`RSEL4_HI:`RSEL4_LO];
  assign o_trap_vec  = i_word[`TRAP_HI:`TRAP_LO];
  assign o_ctl_exr   = i_word[`CTL_SEL_BIT];

  // ========================================================================
  // Operation and extension decode (internal encoding of this core)
  always @* begin
    o_opc      = `OPC_NONE;
    o_ext_size = `EXT_NONE;
    o_cond     = 4'h0;
    case (i_word[`OP_HI:`OP_LO])
      4'h0: begin
        case (i_word[`OP2_HI:`OP2_LO])
          4'h0: o_opc = `OPC_NOP;
          4'h1: o_opc = `OPC_SLEEP;
          4'h2: o_opc = `OPC_RET;
          4'h3: o_opc = `OPC_EXCRET;
          4'h4: o_opc = `OPC_TRAP;
          4'h5: o_opc = `OPC_LDC;
          4'h6: o_opc = `OPC_STC;
          4'h7: o_opc = `OPC_AND_CTRL_IMM_OP;
          4'h8: o_opc = `OPC_ORC;
          4'h9: o_opc = `OPC_XOR_CTRL_IMM_OP;
          4'hA: o_opc = `OPC_MOVB;
          4'hB: o_opc = `OPC_MOVW;
          default: o_opc = `OPC_NONE;
        endcase
      end
      4'h4: begin
        o_opc  = `OPC_BCC;
        o_cond = i_word[`COND_HI:`COND_LO];
        o_ext_size = `EXT_8;
      end
      4'h5: begin
        o_opc = `OPC_JUMP;
        o_ext_size = `EXT_32;
      end
      4'h6: begin
        o_opc = `OPC_RCALL;
        o_ext_size = `EXT_16;
      end
      4'h7: begin
        o_opc = `OPC_ACALL;
        o_ext_size = `EXT_32;
      end
      default: o_opc = `OPC_NONE;
    endcase
  end
endmodule

//--- sysctl_exec.v
// Execution unit for jumps, calls, system control and block moves
`timescale 1ns/1ps
module sysctl_exec (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_valid,
  input  wire [15:0] i_word,
  input  wire [31:0] i_ext,
  input  wire [31:0] i_operand,
  input  wire        i_src_mem,
  input  wire        i_dst_mem,
  input  wire [31:0] i_count_reg,
  input  wire [31:0] i_src_ptr,
  input  wire [31:0] i_dst_ptr,
  input  wire        i_mem_ack,
  input  wire [15:0] i_mem_rdata,
  input  wire        i_wake,
  output reg         o_busy,
  output reg  [23:0] o_pc,
  output reg  [31:0] o_sp,
  output reg  [7:0]  o_ccr,
  output reg  [7:0]  o_exr,
  output reg         o_mem_req,
  output reg         o_mem_we,
  output reg         o_mem_word,
  output reg  [31:0] o_mem_addr,
  output reg  [15:0] o_mem_wdata,
  output reg  [31:0] o_gpr_wdata,
  output reg         o_gpr_we,
  output reg  [3:0]  o_gpr_sel,
  output reg  [15:0] o_count_out,
  output reg  [31:0] o_src_out,
  output reg  [31:0] o_dst_out,
  output reg         o_ptr_we,
  output reg         o_trap_start,
  output reg  [23:0] o_trap_vector,
  output reg         o_sleeping
);
`include "sysctl_map.vh"

  // ========================================================================
  // States
  localparam [5:0] ST_IDLE  = 6'b000001;
  localparam [5:0] ST_MEM   = 6'b000010;
  localparam [5:0] ST_MRD   = 6'b000100;
  localparam [5:0] ST_MWR   = 6'b001000;
  localparam [5:0] ST_SLEEP = 6'b010000;
  localparam [5:0] ST_RTE   = 6'b100000;

  // Memory access purpose
  localparam [2:0] MP_PUSH = 3'h0;
  localparam [2:0] MP_POP  = 3'h1;
  localparam [2:0] MP_LDC  = 3'h2;
  localparam [2:0] MP_STC  = 3'h3;
  localparam [2:0] MP_RTE  = 3'h4;

  wire [4:0] opc;
  wire [1:0] ext_size;
  wire [3:0] cond;
  wire [1:0] trap_vec;
  wire       ctl_exr;
  wire [3:0] dsel;
  wire       take;

  sysctl_decode u_dec (
    .i_word      (i_word),
    .o_opc       (opc),
    .o_op_field  (),
    .o_op2_field (),
    .o_areg_sel  (),
    .o_dreg_sel  (dsel),
    .o_ext_size  (ext_size),
    .o_cond      (cond),
    .o_trap_vec  (trap_vec),
    .o_ctl_exr   (ctl_exr)
  );

  sysctl_cond u_cond (
    .i_cond (cond),
    .i_ccr  (o_ccr),
    .o_take (take)
  );

  reg [5:0]  state;
  reg [2:0]  purpose;
  reg        tgt_exr;
  reg        move_word;
  reg [15:0] count;
  reg [23:0] target;

  // Length in bytes: one code word plus the extension bytes
  function [23:0] instr_len;
    input [1:0] sz;
    begin
      case (sz)
        `EXT_16: instr_len = 24'h000004;
        `EXT_32: instr_len = 24'h000006;
        default: instr_len = `PC_STEP;
      endcase
    end
  endfunction

  // Sign-extended displacement of given extension size
  function [23:0] sext;
    input [1:0]  sz;
    input [31:0] v;
    begin
      case (sz)
        `EXT_8:  sext = {{16{v[7]}}, v[7:0]};
        `EXT_16: sext = {{8{v[15]}}, v[15:0]};
        default: sext = v[23:0];
      endcase
    end
  endfunction

  // Branch keeps its 8-bit displacement in the code word
  wire [23:0] next_pc  = o_pc + instr_len(ext_size);
  wire [23:0] rel_tgt  = next_pc + ((opc == `OPC_BCC) ?
                         sext(`EXT_8, {24'h000000, i_word[7:0]}) :
                         sext(ext_size, i_ext));
  wire [7:0]  imm      = i_word[`IMM_HI:`IMM_LO];
  wire [7:0]  ctl_now  = ctl_exr ? o_exr : o_ccr;
  wire [15:0] start_cnt = (opc == `OPC_MOVW) ? i_count_reg[15:0] :
                          {8'h00, i_count_reg[7:0]};

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state        <= ST_IDLE;
      purpose      <= MP_PUSH;
      tgt_exr      <= 1'b0;
      move_word    <= 1'b0;
      count        <= 16'h0000;
      target       <= `PC_RESET;
      o_busy       <= 1'b0;
      o_pc         <= `PC_RESET;
      o_sp         <= `SP_RESET;
      o_ccr        <= `CCR_RESET;
      o_exr        <= `EXR_RESET;
      o_mem_req    <= 1'b0;
      o_mem_we     <= 1'b0;
      o_mem_word   <= 1'b0;
      o_mem_addr   <= 32'h00000000;
      o_mem_wdata  <= 16'h0000;
      o_gpr_wdata  <= 32'h00000000;
      o_gpr_we     <= 1'b0;
      o_gpr_sel    <= 4'h0;
      o_count_out  <= 16'h0000;
      o_src_out    <= 32'h00000000;
      o_dst_out    <= 32'h00000000;
      o_ptr_we     <= 1'b0;
      o_trap_start <= 1'b0;
      o_trap_vector <= 24'h000000;
      o_sleeping   <= 1'b0;
    end else begin
      o_gpr_we     <= 1'b0;
      o_ptr_we     <= 1'b0;
      o_trap_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_valid) begin
            o_pc <= next_pc;
            case (opc)
              `OPC_JUMP: o_pc <= i_ext[23:0] & `PC_MASK;
              `OPC_BCC: if (take) o_pc <= rel_tgt & `PC_MASK;
              `OPC_RCALL, `OPC_ACALL: begin
                target <= (opc == `OPC_RCALL) ? rel_tgt & `PC_MASK :
                          i_ext[23:0] & `PC_MASK;
                o_sp        <= o_sp - `STACK_STEP;
                o_mem_addr  <= o_sp - `STACK_STEP;
                o_mem_wdata <= next_pc[15:0];
                o_mem_we    <= 1'b1;
                o_mem_word  <= 1'b1;
                o_mem_req   <= 1'b1;
                purpose     <= MP_PUSH;
                o_busy      <= 1'b1;
                state       <= ST_MEM;
              end
              `OPC_RET: begin
                o_mem_addr <= o_sp;
                o_mem_we   <= 1'b0;
                o_mem_word <= 1'b1;
                o_mem_req  <= 1'b1;
                purpose    <= MP_POP;
                o_busy     <= 1'b1;
                state      <= ST_MEM;
              end
              `OPC_TRAP: begin
                o_trap_vector <= `TRAP_VEC_BASE +
                                 {20'h00000, trap_vec, 2'b00};
                o_trap_start  <= 1'b1;
              end
              `OPC_EXCRET: begin
                o_mem_addr <= o_sp;
                o_mem_we   <= 1'b0;
                o_mem_word <= 1'b1;
                o_mem_req  <= 1'b1;
                purpose    <= MP_RTE;
                o_busy     <= 1'b1;
                state      <= ST_MEM;
              end
              `OPC_SLEEP: begin
                o_sleeping <= 1'b1;
                o_busy     <= 1'b1;
                state      <= ST_SLEEP;
              end
              `OPC_LDC: begin
                tgt_exr <= ctl_exr;
                if (i_src_mem) begin
                  o_mem_addr <= i_operand;
                  o_mem_we   <= 1'b0;
                  o_mem_word <= 1'b1;
                  o_mem_req  <= 1'b1;
                  purpose    <= MP_LDC;
                  o_busy     <= 1'b1;
                  state      <= ST_MEM;
                end else if (ctl_exr)
                  o_exr <= i_operand[7:0];
                else
                  o_ccr <= i_operand[7:0];
              end
              `OPC_STC: begin
                if (i_dst_mem) begin
                  o_mem_addr  <= i_operand;
                  o_mem_wdata <= {ctl_now, 8'h00};
                  o_mem_we    <= 1'b1;
                  o_mem_word  <= 1'b1;
                  o_mem_req   <= 1'b1;
                  purpose     <= MP_STC;
                  o_busy      <= 1'b1;
                  state       <= ST_MEM;
                end else begin
                  o_gpr_sel   <= dsel;
                  o_gpr_wdata <= {24'h000000, ctl_now};
                  o_gpr_we    <= 1'b1;
                end
              end
              `OPC_AND_CTRL_IMM_OP: if (ctl_exr) o_exr <= o_exr & imm;
                         else o_ccr <= o_ccr & imm;
              `OPC_ORC:  if (ctl_exr) o_exr <= o_exr | imm;
                         else o_ccr <= o_ccr | imm;
              `OPC_XOR_CTRL_IMM_OP: if (ctl_exr) o_exr <= o_exr ^ imm;
                         else o_ccr <= o_ccr ^ imm;
              `OPC_NOP: o_pc <= o_pc + `PC_STEP;
              `OPC_MOVB, `OPC_MOVW: begin
                move_word <= (opc == `OPC_MOVW);
                if (start_cnt != 16'h0000) begin
                  count      <= start_cnt;
                  o_src_out  <= i_src_ptr;
                  o_dst_out  <= i_dst_ptr;
                  o_mem_addr <= i_src_ptr;
                  o_mem_we   <= 1'b0;
                  o_mem_word <= 1'b0;
                  o_mem_req  <= 1'b1;
                  o_busy     <= 1'b1;
                  state      <= ST_MRD;
                end
              end
              default: o_pc <= next_pc;
            endcase
          end
        end
        ST_MEM: if (i_mem_ack) begin
          o_mem_req <= 1'b0;
          o_busy    <= 1'b0;
          state     <= ST_IDLE;
          case (purpose)
            MP_PUSH: o_pc <= target;
            MP_POP: begin
              o_pc <= {8'h00, i_mem_rdata} & `PC_MASK;
              o_sp <= o_sp + `STACK_STEP;
            end
            MP_LDC: if (tgt_exr) o_exr <= i_mem_rdata[15:8];
                    else o_ccr <= i_mem_rdata[15:8];
            MP_RTE: begin
              // Saved word holds the flags in the upper byte
              o_ccr      <= i_mem_rdata[15:8];
              o_mem_addr <= o_sp + `STACK_STEP;
              o_sp       <= o_sp + `STACK_STEP;
              o_mem_req  <= 1'b1;
              o_busy     <= 1'b1;
              state      <= ST_RTE;
            end
            default: o_mem_req <= 1'b0;
          endcase
        end
        ST_RTE: if (i_mem_ack) begin
          o_pc      <= {8'h00, i_mem_rdata} & `PC_MASK;
          o_sp      <= o_sp + `STACK_STEP;
          o_mem_req <= 1'b0;
          o_busy    <= 1'b0;
          state     <= ST_IDLE;
        end
        ST_MRD: if (i_mem_ack) begin
          o_mem_addr  <= o_dst_out;
          o_mem_wdata <= {8'h00, i_mem_rdata[7:0]};
          o_mem_we    <= 1'b1;
          state       <= ST_MWR;
        end
        ST_MWR: if (i_mem_ack) begin
          // Pointers and count written back every byte so that
          // an interrupted move can resume from the registers
          o_src_out   <= o_src_out + 32'h00000001;
          o_dst_out   <= o_dst_out + 32'h00000001;
          count       <= count - 16'h0001;
          o_count_out <= count - 16'h0001;
          o_ptr_we    <= 1'b1;
          o_mem_we    <= 1'b0;
          if (count == 16'h0001) begin
            o_mem_req <= 1'b0;
            o_busy    <= 1'b0;
            state     <= ST_IDLE;
          end else begin
            o_mem_addr <= o_src_out + 32'h00000001;
            state      <= ST_MRD;
          end
        end
        ST_SLEEP: if (i_wake) begin
          o_sleeping <= 1'b0;
          o_busy     <= 1'b0;
          state      <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- sysctl_exec_monitor.sv
// Concurrent checks on the execution block ports
`timescale 1ns/1ps
`include "sysctl_map.vh"
module sysctl_exec_monitor (
  input wire        i_clk,
  input wire        i_rst,
  input wire        i_valid,
  input wire [15:0] i_word,
  input wire [31:0] i_ext,
  input wire [31:0] i_count_reg,
  input wire [31:0] i_src_ptr,
  input wire        i_mem_ack,
  input wire        i_wake,
  input wire        o_busy,
  input wire [23:0] o_pc,
  input wire [7:0]  o_ccr,
  input wire        o_mem_req,
  input wire        o_mem_we,
  input wire [31:0] o_mem_addr,
  input wire        o_trap_start,
  input wire [23:0] o_trap_vector,
  input wire        o_sleeping
);
  // ==========================================================
  // State seen at the taking edge
  wire       take = i_valid && !o_busy;
  reg [23:0] pc_cap;
  reg [31:0] ext_cap;
  reg [7:0]  ccr_cap;
  reg [15:0] word_cap;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pc_cap   <= 24'h000000;
      ext_cap  <= 32'h00000000;
      ccr_cap  <= 8'h00;
      word_cap <= 16'h0000;
    end else if (take) begin
      pc_cap   <= o_pc;
      ext_cap  <= i_ext;
      ccr_cap  <= o_ccr;
      word_cap <= i_word;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Assertions
  a_nop_pc_step: assert property (take && i_word == 16'h0000 |->
    ##[1:2] o_pc == pc_cap + 24'h000002) else $error("nop pc step");
  a_jump_target: assert property (take && i_word[15:12] == 4'h5 |->
    ##[1:2] o_pc == (ext_cap[23:0] & `PC_MASK)) else $error("jump pc");
  a_and_ccr: assert property (take && i_word[15:8] == 8'h07 &&
    !i_word[0] |-> ##[1:2] o_ccr == (ccr_cap & word_cap[7:0]))
    else $error("and ccr");
  a_xor_ccr: assert property (take && i_word[15:8] == 8'h09 &&
    !i_word[0] |-> ##[1:2] o_ccr == (ccr_cap ^ word_cap[7:0]))
    else $error("xor ccr");
  a_trap_vec_range: assert property (o_trap_start |->
    o_trap_vector[1:0] == 2'b00 && o_trap_vector >= `TRAP_VEC_BASE &&
    o_trap_vector <= `TRAP_VEC_BASE + 24'h00000C) else $error("trap vec");
  a_byte_zero_skip: assert property (take && i_word[15:8] == 8'h0A &&
    i_count_reg[7:0] == 8'h00 |=> (!o_mem_req) [*3]) else $error("zero move");
  a_move_first_read: assert property (take && i_word[15:8] == 8'h0A &&
    i_count_reg[7:0] != 8'h00 |=> o_mem_req && !o_mem_we &&
    o_mem_addr == $past(i_src_ptr)) else $error("move first read");
  a_mem_req_hold: assert property (o_mem_req && !i_mem_ack |=>
    o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we))
    else $error("mem request dropped");
  a_wake_exit: assert property (o_sleeping && i_wake |->
    ##[1:2] !o_sleeping) else $error("no wake");
  c_trap: cover property (o_trap_start);
  c_mem_write: cover property (o_mem_req && o_mem_we && i_mem_ack);
  c_wake: cover property (o_sleeping && i_wake);
endmodule
bind sysctl_exec sysctl_exec_monitor u_mon (.*);

//--- sysctl_map.vh
// Constants for the system-control and block-move execution block
// How it works
// - Jump loads the PC with the operand target, no condition.
// - Trap's 2-bit immediate selects the vector address.
// - Load-control writes operand or immediate to a control register.
// - Control registers move to memory as words; upper byte valid.
// - Store-control copies a control register to register or memory.
// - AND-to-control: register becomes old AND immediate byte.
// - OR-to-control: register becomes old OR immediate byte.
// - XOR-to-control: register becomes old XOR immediate byte.
// - No-operation only advances the PC by two.
// - Byte move uses the low count byte; zero skips it.
// - Word move uses the full 16-bit count; zero skips it.
// - Count is bytes; pointers give start addresses.
// - Next instruction starts right after the last byte.
// - Instructions are whole 16-bit words.
// - Fields: operation, register, address extension, condition.
// - Operation field is the leading 4 bits of word one.
// - Address selectors 3 bits; data selectors 3 or 4 bits.
// - Extensions: 8, 16 or 32 bit immediate, address or displacement.
// - Condition field decoded only for conditional branches.
// - Relative branch: displacement plus next instruction address.
`ifndef SYSCTL_MAP_VH
`define SYSCTL_MAP_VH

// ==========================================================================
// Internal operation codes (decoder to executor)
`define OPC_W        5
`define OPC_NONE     5'h00
`define OPC_JUMP     5'h01
`define OPC_RCALL    5'h02
`define OPC_ACALL    5'h03
`define OPC_RET      5'h04
`define OPC_TRAP     5'h05
`define OPC_EXCRET   5'h06
`define OPC_SLEEP    5'h07
`define OPC_LDC      5'h08
`define OPC_STC      5'h09
`define OPC_AND_CTRL_IMM_OP     5'h0A
`define OPC_ORC      5'h0B
`define OPC_XOR_CTRL_IMM_OP     5'h0C
`define OPC_NOP      5'h0D
`define OPC_MOVB     5'h0E
`define OPC_MOVW     5'h0F
`define OPC_BCC      5'h10

// ==========================================================================
// Instruction word fields
`define OP_HI        15
`define OP_LO        12
`define OP2_HI       11
`define OP2_LO       8
`define RSEL_HI      6
`define RSEL_LO      4
`define RSEL4_HI     3
`define RSEL4_LO     0
`define CTL_SEL_BIT  0
`define IMM_HI       7
`define IMM_LO       0
`define TRAP_HI      5
`define TRAP_LO      4
`define COND_HI      11
`define COND_LO      8

// ==========================================================================
// Extension size codes
`define EXT_NONE     2'h0
`define EXT_8        2'h1
`define EXT_16       2'h2
`define EXT_32       2'h3

// ==========================================================================
// Address constants
`define PC_STEP      24'h000002
`define STACK_STEP   32'h00000004
`define TRAP_VEC_BASE 24'h000020
`define VEC_SHIFT    2
`define PC_RESET     24'h000000
`define SP_RESET     32'h00FFFF00
`define CCR_RESET    8'h80
`define EXR_RESET    8'h07
`define PC_MASK      24'hFFFFFE

`endif

//--- sysctl_mem_model.sv
// Memory bus partner with programmable acknowledge delay
`timescale 1ns/1ps
module sysctl_mem_model (
  input  wire        i_clk,
  input  wire [3:0]  i_delay,
  input  wire        i_mem_req,
  input  wire        i_mem_we,
  input  wire        i_mem_word,
  input  wire [31:0] i_mem_addr,
  input  wire [15:0] i_mem_wdata,
  output reg         o_mem_ack,
  output reg  [15:0] o_mem_rdata
);
  reg [7:0]  mem [0:255];
  reg [3:0]  wait_cnt;
  integer    n_writes;
  wire [7:0] a_hi = {i_mem_addr[7:1], 1'b0};
  wire [7:0] a_lo = {i_mem_addr[7:1], 1'b1};
  initial begin
    o_mem_ack   = 1'b0;
    o_mem_rdata = 16'hA5A5;
    wait_cnt    = 4'h0;
    n_writes    = 0;
  end
  // ==========================================================
  // Ack one cycle; read data toggles when not valid
  always @(negedge i_clk) begin
    if (!i_mem_req || o_mem_ack) begin
      o_mem_ack   <= 1'b0;
      wait_cnt    <= 4'h0;
      o_mem_rdata <= ~o_mem_rdata;
    end else if (wait_cnt < i_delay) begin
      wait_cnt    <= wait_cnt + 4'h1;
      o_mem_rdata <= ~o_mem_rdata;
    end else begin
      o_mem_ack <= 1'b1;
      if (i_mem_we) begin
        n_writes <= n_writes + 1;
        if (i_mem_word) begin
          mem[a_hi] <= i_mem_wdata[15:8];
          mem[a_lo] <= i_mem_wdata[7:0];
        end else begin
          mem[i_mem_addr[7:0]] <= i_mem_wdata[7:0];
        end
      end else if (i_mem_word) begin
        o_mem_rdata <= {mem[a_hi], mem[a_lo]};
      end else begin
        o_mem_rdata <= {2{mem[i_mem_addr[7:0]]}};
      end
    end
  end
endmodule

//--- system_ctrl_instr_exec_tb_top.sv
// Self-checking bench for the system-control execution block
`timescale 1ns/1ps
`include "sysctl_map.vh"
`define CHECK_EQ(got, exp, msg) begin checks = checks + 1; \
  if ((got) !== (exp)) begin n_errors = n_errors + 1; \
  $display("CHECK FAILED t=%0t %s", $time, msg); end end
module system_ctrl_instr_exec_tb_top;
  reg         i_clk, i_rst, i_valid, i_src_mem, i_dst_mem, i_wake;
  reg  [15:0] i_word;
  reg  [31:0] i_ext, i_operand, i_count_reg, i_src_ptr, i_dst_ptr;
  reg  [3:0]  delay;
  wire        o_busy, o_mem_req, o_mem_we, o_mem_word, o_gpr_we;
  wire        o_trap_start, o_sleeping, i_mem_ack, o_ptr_we;
  wire [3:0]  o_gpr_sel;
  wire [23:0] o_pc, o_trap_vector;
  wire [31:0] o_sp, o_mem_addr, o_gpr_wdata, o_src_out, o_dst_out;
  wire [15:0] o_mem_wdata, o_count_out, i_mem_rdata;
  wire [7:0]  o_ccr, o_exr;
  integer     n_errors, checks, n_trap, i;
  reg  [7:0]  ccr_m, exr_m;
  reg  [11:0] gpr_seen;
  reg  [23:0] vec_seen;
  reg  [15:0] lw [0:5];
  sysctl_exec uut (.*);
  sysctl_mem_model mem_mdl (.i_clk(i_clk), .i_delay(delay),
    .i_mem_req(o_mem_req), .i_mem_we(o_mem_we), .i_mem_word(o_mem_word),
    .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata),
    .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // Pulses last one cycle, so latch them here
  always @(posedge i_clk) begin
    if (o_gpr_we === 1'b1)
      gpr_seen <= {o_gpr_sel, o_gpr_wdata[7:0]};
    if (o_trap_start === 1'b1) begin
      n_trap   <= n_trap + 1;
      vec_seen <= o_trap_vector;
    end
  end
  // ==========================================================
  // Shared tasks
  task test_done;
    begin
      $display("errors=%0d checks=%0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // No test-and-set is issued, so its pointer advice holds
  task issue(input [15:0] w, input [31:0] e = 32'h0, input wt = 1'b1);
    integer k;
    begin
      @(negedge i_clk);
      i_word = w;
      i_ext = e;
      i_valid = 1'b1;
      @(negedge i_clk);
      i_valid = 1'b0;
      @(negedge i_clk);
      k = 0;
      while (wt && o_busy !== 1'b0 && k < 400) begin
        @(negedge i_clk);
        k = k + 1;
      end
      `CHECK_EQ(k < 400, 1'b1, "busy stuck")
      @(negedge i_clk);
    end
  endtask
  task move_run(input [15:0] w, input [31:0] cnt, input [7:0] src, dst,
                input integer n);
    integer n0;
    begin
      for (i = 0; i < 4; i = i + 1)
        mem_mdl.mem[src + i] = (src + i) ^ 8'h5A;
      n0 = mem_mdl.n_writes;
      i_count_reg = cnt;
      i_src_ptr = {24'h000000, src};
      i_dst_ptr = {24'h000000, dst};
      issue(16'h5000, 32'h00004000);
      issue(w);
      `CHECK_EQ(mem_mdl.n_writes - n0, n, "move count")
      for (i = 0; i < n; i = i + 1)
        `CHECK_EQ(mem_mdl.mem[dst + i], (src + i) ^ 8'h5A, "move data")
      `CHECK_EQ(o_pc, 24'h004002, "next after move")
      if (n > 0) begin
        `CHECK_EQ(o_src_out, i_src_ptr + n, "src ptr")
        `CHECK_EQ(o_dst_out, i_dst_ptr + n, "dst ptr")
      end
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_branch;
    begin
      issue(16'h5000, 32'h00001000);
      `CHECK_EQ(o_pc, 24'h001000, "jump target")
      issue(16'h0000);
      `CHECK_EQ(o_pc, 24'h001002, "nop step")
      `CHECK_EQ({o_ccr, o_exr, o_sp}, {ccr_m, exr_m, `SP_RESET}, "nop")
      issue(16'h4010);
      `CHECK_EQ(o_pc, 24'h001014, "branch forward")
      issue(16'h40F0);
      `CHECK_EQ(o_pc, 24'h001006, "branch back")
      issue(16'h4110);
      `CHECK_EQ(o_pc, 24'h001008, "never taken")
    end
  endtask
  task t_logic;
    reg [7:0] old;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        old = lw[i][0] ? exr_m : ccr_m;
        old = (lw[i][11:8] == 4'h7) ? old & lw[i][7:0] :
              (lw[i][11:8] == 4'h8) ? old | lw[i][7:0] : old ^ lw[i][7:0];
        if (lw[i][0])
          exr_m = old;
        else
          ccr_m = old;
        issue(lw[i]);
        `CHECK_EQ({o_ccr, o_exr}, {ccr_m, exr_m}, "ctrl logic")
      end
    end
  endtask
  task t_ctrl_move;
    begin
      i_operand = 32'h0000005A;
      issue(16'h0500);
      ccr_m = 8'h5A;
      `CHECK_EQ(o_ccr, ccr_m, "load from reg")
      mem_mdl.mem[16] = 8'hC3;
      mem_mdl.mem[17] = 8'h3C;
      i_operand = 32'h00000010;
      i_src_mem = 1'b1;
      issue(16'h0501);
      exr_m = 8'hC3;
      `CHECK_EQ(o_exr, exr_m, "load upper byte")
      i_src_mem = 1'b0;
      issue(16'h0606);
      `CHECK_EQ(gpr_seen, {4'h6, ccr_m}, "store to reg")
      i_dst_mem = 1'b1;
      i_operand = 32'h00000020;
      issue(16'h0601);
      `CHECK_EQ(mem_mdl.mem[32], exr_m, "store upper byte")
      i_dst_mem = 1'b0;
    end
  endtask
  task t_call;
    begin
      issue(16'h5000, 32'h00002000);
      issue(16'h7000, 32'h00000300);
      `CHECK_EQ({o_pc, o_sp}, {24'h000300, `SP_RESET - 32'h4}, "call")
      issue(16'h0200);
      `CHECK_EQ(o_pc, 24'h002006, "ret")
      `CHECK_EQ(o_sp, `SP_RESET, "ret sp")
      issue(16'h5000, 32'h00003000);
      issue(16'h6000, 32'h00000020);
      `CHECK_EQ({o_pc, o_sp}, {24'h003024, `SP_RESET - 32'h4}, "rel")
      issue(16'h0200);
      `CHECK_EQ({o_pc, o_sp}, {24'h003004, `SP_RESET}, "rel ret")
    end
  endtask
  task t_trap;
    integer n0;
    reg [23:0] ev;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        n0 = n_trap;
        ev = `TRAP_VEC_BASE + {20'h0, i[1:0], 2'b00};
        issue({8'h04, 2'b00, i[1:0], 4'h0});
        `CHECK_EQ(n_trap - n0, 1, "trap count")
        `CHECK_EQ(vec_seen, ev, "trap vector")
      end
    end
  endtask
  task t_sleep_exc;
    begin
      issue(16'h0100, 32'h0, 1'b0);
      `CHECK_EQ(o_sleeping, 1'b1, "sleep entry")
      i_wake = 1'b1;
      @(negedge i_clk);
      i_wake = 1'b0;
      repeat (3) @(negedge i_clk);
      `CHECK_EQ(o_sleeping, 1'b0, "wake")
      mem_mdl.mem[0] = 8'h8A;
      mem_mdl.mem[1] = 8'h00;
      mem_mdl.mem[4] = 8'h05;
      mem_mdl.mem[5] = 8'h00;
      issue(16'h0300);
      ccr_m = 8'h8A;
      `CHECK_EQ({o_ccr, o_pc}, {ccr_m, 24'h000500}, "exc return")
      `CHECK_EQ(o_sp, `SP_RESET + 32'h8, "exc sp")
    end
  endtask
  task t_moves;
    begin
      delay = 4'h2;
      move_run(16'h0A00, 32'h00000103, 8'h40, 8'h60, 3);
      `CHECK_EQ(o_count_out[7:0], 8'h00, "count end")
      move_run(16'h0A00, 32'h00000100, 8'h40, 8'h70, 0);
      delay = 4'h0;
      move_run(16'h0B00, 32'h00000004, 8'h40, 8'h80, 4);
      move_run(16'h0B00, 32'h00010000, 8'h40, 8'h90, 0);
    end
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    n_errors = 0;
    checks = 0;
    n_trap = 0;
    {i_rst, i_valid, i_src_mem, i_dst_mem, i_wake} = 5'b10000;
    {i_word, i_ext, i_operand} = 80'h0;
    {i_count_reg, i_src_ptr, i_dst_ptr} = 96'h0;
    delay = 4'h0;
    ccr_m = `CCR_RESET;
    exr_m = `EXR_RESET;
    lw[0] = 16'h07F6;
    lw[1] = 16'h0812;
    lw[2] = 16'h09C0;
    lw[3] = 16'h0705;
    lw[4] = 16'h08A1;
    lw[5] = 16'h090F;
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    t_branch;
    t_logic;
    t_ctrl_move;
    t_call;
    t_trap;
    t_sleep_exc;
    t_moves;
    test_done;
  end
  initial begin
    #(100 * 6000);
    n_errors = n_errors + 1;
    test_done;
  end
endmodule
